// ==== rtl/esm_pkg.sv ====
package esm_pkg;
  // device clock and sampling window of the speed measurement
  localparam int CLK_HZ = 10_000_000;
  localparam int SAMPLE_MS = 10;
  localparam int SAMPLE_CYC = SAMPLE_MS * (CLK_HZ / 1000);
  // rpm per count of one window, before division by the line count
  localparam logic [31:0] RPM_RATE = 32'(60 * 1000 / SAMPLE_MS);
  // line count and top speed limits
  localparam logic [12:0] LINES_MIN = 13'h000A;
  localparam logic [12:0] LINES_MAX = 13'h1388;
  localparam logic [12:0] RPM_MAX = 13'h1770;
  // four counts per line in quadrature
  localparam int QUAD_SHIFT = 2;
  // percent reported in tenths, so full scale reads 1000
  localparam logic [31:0] PCT_SCALE = 32'h000003E8;
  localparam logic [15:0] PCT_FULL = 16'h03E8;
  localparam logic [15:0] RPM_CLAMP = 16'h7FFF;
  localparam int FRAC_BITS = 12;
  // input mode selector codes
  localparam logic MODE_PULSE_DIR = 1'b0;
  localparam logic MODE_QUAD = 1'b1;
  localparam int PULSE_DIR_INSTANCE = 2;
  typedef enum logic [1:0] {ST_IDLE, ST_RPM, ST_PCT} esm_state_t;
endpackage

// ==== rtl/esm_udiv.sv ====
`timescale 1ns/10ps
`default_nettype none
module esm_udiv #(
  parameter int NW = 32,
  parameter int DW = 16
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // request
  input wire logic start_i,
  input wire logic [NW-1:0] num_i,
  input wire logic [DW-1:0] den_i,
  // answer
  output logic done_o,
  output logic [NW-1:0] quo_o
);
  localparam int CW = $clog2(NW + 1);
  logic [NW-1:0] quo_r, quo_nxt;
  logic [DW:0] rem_r, rem_nxt;
  logic [DW-1:0] den_r, den_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic busy_r, busy_nxt, done_r, done_nxt;
  logic [DW:0] trial;

  // restoring divider, one quotient bit a cycle; a zero divisor yields all ones
  always_comb begin
    quo_nxt = quo_r;
    rem_nxt = rem_r;
    den_nxt = den_r;
    cnt_nxt = cnt_r;
    busy_nxt = busy_r;
    done_nxt = 1'b0;
    trial = {rem_r[DW-1:0], quo_r[NW-1]};
    if (start_i && !busy_r) begin
      quo_nxt = num_i;
      rem_nxt = '0;
      den_nxt = den_i;
      cnt_nxt = CW'(NW);
      busy_nxt = 1'b1;
    end else if (busy_r) begin
      if (trial >= {1'b0, den_r}) begin
        rem_nxt = trial - {1'b0, den_r};
        quo_nxt = {quo_r[NW-2:0], 1'b1};
      end else begin
        rem_nxt = trial;
        quo_nxt = {quo_r[NW-2:0], 1'b0};
      end
      cnt_nxt = cnt_r - CW'(1);
      if (cnt_r == CW'(1)) begin
        busy_nxt = 1'b0;
        done_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      quo_r <= '0;
      rem_r <= '0;
      den_r <= '0;
      cnt_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      quo_r <= quo_nxt;
      rem_r <= rem_nxt;
      den_r <= den_nxt;
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
    end
  end

  assign done_o = done_r;
  assign quo_o = quo_r;
endmodule // esm_udiv
`default_nettype wire

// ==== rtl/esm_speed_meas.sv ====
`timescale 1ns/10ps
`default_nettype none
module esm_speed_meas
  import esm_pkg::*;
#(
  parameter int INSTANCE = PULSE_DIR_INSTANCE,
  parameter int SAMPLE_CYCLES = SAMPLE_CYC
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // encoder pins
  input wire logic pulse_input_terminal_i,
  input wire logic direction_input_terminal_i,
  // configuration
  input wire logic input_mode_i,
  input wire logic sign_positive_i,
  input wire logic [12:0] line_count_i,
  input wire logic [12:0] full_scale_speed_i,
  input wire logic [3:0] filter_shift_i,
  // status
  output logic [31:0] enc_count_o,
  output logic [15:0] raw_speed_rpm_o,
  output logic [15:0] filt_speed_rpm_o,
  output logic [15:0] speed_pct_o,
  output logic speed_valid_o,
  output logic mode_active_o
);
  // input synchronisers and edge history
  logic pa_s1_r, pa_s2_r, pa_d_r, pb_s1_r, pb_s2_r, pb_d_r;
  logic mode_r, mode_nxt;
  logic signed [31:0] count_r, count_nxt;
  logic step_en, step_up, mode_eff;

  // sampling, division and filter state
  esm_state_t state_r, state_nxt;
  logic [31:0] tick_r, tick_nxt;
  logic signed [31:0] last_r, last_nxt;
  logic neg_r, neg_nxt;
  logic [15:0] mag_r, mag_nxt;
  logic signed [15:0] raw_r, raw_nxt, pct_r, pct_nxt;
  logic signed [31:0] acc_r, acc_nxt;
  logic valid_r, valid_nxt;
  logic div_start_r, div_start_nxt;
  logic [31:0] div_num_r, div_num_nxt;
  logic [15:0] div_den_r, div_den_nxt;
  logic div_done;
  logic [31:0] div_quo;
  logic tick;
  logic signed [31:0] delta;
  logic [31:0] dmag;
  logic [12:0] lines_eff, fs_eff;
  logic [15:0] rpm_q;
  logic signed [31:0] acc_err;
  logic signed [15:0] raw_new;

  // pulse-and-direction exists only where the digital inputs feed this instance
  assign mode_eff = (INSTANCE == PULSE_DIR_INSTANCE) ? input_mode_i : MODE_QUAD;
  assign lines_eff = (line_count_i < LINES_MIN) ? LINES_MIN :
                     (line_count_i > LINES_MAX) ? LINES_MAX : line_count_i;
  assign fs_eff = (full_scale_speed_i > RPM_MAX) ? RPM_MAX : full_scale_speed_i;

  always_comb begin
    mode_nxt = mode_eff;
    if (mode_r == MODE_PULSE_DIR) begin
      step_en = pa_s2_r & ~pa_d_r;
      step_up = pb_s2_r;
    end else begin
      step_en = (pa_s2_r ^ pa_d_r) ^ (pb_s2_r ^ pb_d_r);
      step_up = pa_s2_r ^ pb_d_r;
    end
    // a simultaneous change of both phases is illegal and is dropped
    count_nxt = count_r;
    if (step_en) begin
      if (step_up ^ ~sign_positive_i) begin
        count_nxt = count_r + 32'sh1;
      end else begin
        count_nxt = count_r - 32'sh1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      pa_s1_r <= 1'b0;
      pa_s2_r <= 1'b0;
      pa_d_r <= 1'b0;
      pb_s1_r <= 1'b0;
      pb_s2_r <= 1'b0;
      pb_d_r <= 1'b0;
      mode_r <= MODE_QUAD;
      count_r <= '0;
    end else begin
      pa_s1_r <= pulse_input_terminal_i;
      pa_s2_r <= pa_s1_r;
      pa_d_r <= pa_s2_r;
      pb_s1_r <= direction_input_terminal_i;
      pb_s2_r <= pb_s1_r;
      pb_d_r <= pb_s2_r;
      mode_r <= mode_nxt;
      count_r <= count_nxt;
    end
  end

  assign tick = (tick_r == 32'h0);
  assign delta = count_r - last_r;
  assign dmag = delta[31] ? 32'(-delta) : 32'(delta);
  assign rpm_q = (div_quo > {16'h0, RPM_CLAMP}) ? RPM_CLAMP : div_quo[15:0];
  // signed result of this window, kept apart from raw_nxt so the filter input has no loop through the state logic
  assign raw_new = neg_r ? 16'(-$signed(rpm_q)) : $signed(rpm_q);
  assign acc_err = ($signed({{16{raw_new[15]}}, raw_new}) <<< FRAC_BITS) - acc_r;

  // one window: rpm = counts * 60 / (window * lines), lines taken four times in quadrature, then percent of top speed
  always_comb begin
    state_nxt = state_r;
    tick_nxt = tick ? 32'(SAMPLE_CYCLES - 1) : tick_r - 32'h1;
    last_nxt = last_r;
    neg_nxt = neg_r;
    mag_nxt = mag_r;
    raw_nxt = raw_r;
    pct_nxt = pct_r;
    acc_nxt = acc_r;
    valid_nxt = 1'b0;
    div_start_nxt = 1'b0;
    div_num_nxt = div_num_r;
    div_den_nxt = div_den_r;
    case (state_r)
      ST_IDLE: begin
        if (tick) begin
          last_nxt = count_r;
          neg_nxt = delta[31];
          div_num_nxt = 32'(dmag * RPM_RATE);
          if (mode_r == MODE_QUAD) begin
            div_den_nxt = 16'({3'h0, lines_eff} << QUAD_SHIFT);
          end else begin
            div_den_nxt = {3'h0, lines_eff};
          end
          div_start_nxt = 1'b1;
          state_nxt = ST_RPM;
        end
      end
      ST_RPM: begin
        if (div_done) begin
          mag_nxt = rpm_q;
          raw_nxt = raw_new;
          acc_nxt = acc_r + (acc_err >>> filter_shift_i);
          if (fs_eff == 13'h0) begin
            pct_nxt = '0;
            valid_nxt = 1'b1;
            state_nxt = ST_IDLE;
          end else begin
            div_num_nxt = 32'({16'h0, rpm_q} * PCT_SCALE);
            div_den_nxt = {3'h0, fs_eff};
            div_start_nxt = 1'b1;
            state_nxt = ST_PCT;
          end
        end
      end
      ST_PCT: begin
        if (div_done) begin
          pct_nxt = neg_r ? 16'(-$signed(div_quo[15:0])) : $signed(div_quo[15:0]);
          valid_nxt = 1'b1;
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      tick_r <= '0;
      last_r <= '0;
      neg_r <= 1'b0;
      mag_r <= '0;
      raw_r <= '0;
      pct_r <= '0;
      acc_r <= '0;
      valid_r <= 1'b0;
      div_start_r <= 1'b0;
      div_num_r <= '0;
      div_den_r <= '0;
    end else begin
      state_r <= state_nxt;
      tick_r <= tick_nxt;
      last_r <= last_nxt;
      neg_r <= neg_nxt;
      mag_r <= mag_nxt;
      raw_r <= raw_nxt;
      pct_r <= pct_nxt;
      acc_r <= acc_nxt;
      valid_r <= valid_nxt;
      div_start_r <= div_start_nxt;
      div_num_r <= div_num_nxt;
      div_den_r <= div_den_nxt;
    end
  end

  // shared divider keeps area small; a window needs about 70 cycles of it
  esm_udiv #(
    .NW(32),
    .DW(16)
  ) u_div (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .start_i(div_start_r),
    .num_i(div_num_r),
    .den_i(div_den_r),
    .done_o(div_done),
    .quo_o(div_quo)
  );

  assign enc_count_o = count_r;
  assign raw_speed_rpm_o = raw_r;
  assign filt_speed_rpm_o = acc_r[FRAC_BITS+15:FRAC_BITS];
  assign speed_pct_o = pct_r;
  assign speed_valid_o = valid_r;
  assign mode_active_o = mode_r;

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  sequence s_window_start;
    tick && state_r == ST_IDLE;
  endsequence
  sequence s_result;
    ##[1:100] valid_r;
  endsequence

  lines_range_a: assert property (div_start_r && state_r == ST_RPM |->
      div_den_r >= {3'h0, LINES_MIN} && div_den_r <= 16'({3'h0, LINES_MAX} << QUAD_SHIFT))
    else $error("line count divisor out of range");
  pulse_up_a: assert property (mode_r == MODE_PULSE_DIR && pa_s2_r && !pa_d_r && pb_s2_r && sign_positive_i
      |=> count_r == $past(count_r) + 32'sh1)
    else $error("pulse with direction high did not increment");
  pulse_down_a: assert property (mode_r == MODE_PULSE_DIR && pa_s2_r && !pa_d_r && !pb_s2_r && sign_positive_i
      |=> count_r == $past(count_r) - 32'sh1)
    else $error("pulse with direction low did not decrement");
  sign_invert_a: assert property (mode_r == MODE_PULSE_DIR && pa_s2_r && !pa_d_r && pb_s2_r && !sign_positive_i
      |=> count_r == $past(count_r) - 32'sh1)
    else $error("negative polarity did not invert the count");
  pulse_fall_a: assert property (mode_r == MODE_PULSE_DIR && !(pa_s2_r && !pa_d_r)
      |=> count_r == $past(count_r))
    else $error("count moved without a rising pulse edge");
  quad_edge_a: assert property (mode_r == MODE_QUAD && (pa_s2_r != pa_d_r) && (pb_s2_r == pb_d_r)
      |=> count_r != $past(count_r))
    else $error("quadrature edge not counted");
  mode_lock_a: assert property (1'b1 |=>
      mode_r == ((INSTANCE == PULSE_DIR_INSTANCE) ? $past(input_mode_i) : MODE_QUAD))
    else $error("effective input mode not as selected for this instance");
  window_done_a: assert property (s_window_start |-> s_result)
    else $error("speed result not produced after window");
  pct_full_a: assert property (valid_r && fs_eff != 13'h0 && mag_r == {3'h0, fs_eff}
      |-> pct_r == PCT_FULL || pct_r == 16'(-$signed(PCT_FULL)))
    else $error("top speed does not read one hundred percent");
  filt_pass_a: assert property (valid_r && $past(filter_shift_i, 2) == 4'h0 && filter_shift_i == 4'h0
      |-> filt_speed_rpm_o == raw_r)
    else $error("unity filter does not follow raw speed");
endmodule // esm_speed_meas
`default_nettype wire

// ==== testbench/esm_enc_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module esm_enc_model #(
  parameter int HALF = 10
) (
  // clock
  input wire logic mclk_i,
  // mode seen by the encoder
  input wire logic quad_i,
  // encoder lines
  output logic a_o,
  output logic b_o
);
  initial begin
    a_o = 1'b0;
    b_o = 1'b0;
  end
  // each call yields one count; every level is held for many clocks
  task automatic step(input logic fwd);
    logic [1:0] ph;
    ph = {b_o, a_o ^ b_o} + (fwd ? 2'h1 : 2'h3);
    if (quad_i) begin
      @(posedge mclk_i);
      #1;
      b_o = ph[1];
      a_o = ph[1] ^ ph[0];
      repeat (HALF - 1) @(posedge mclk_i);
    end else begin
      @(posedge mclk_i);
      #1 b_o = fwd;
      @(posedge mclk_i);
      #1 a_o = 1'b1;
      repeat (HALF) @(posedge mclk_i);
      #1 a_o = 1'b0;
      repeat (HALF - 2) @(posedge mclk_i);
    end
  endtask
endmodule // esm_enc_model
`default_nettype wire

// ==== testbench/esm_speed_meas_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module esm_speed_meas_test;
  import esm_pkg::*;
  localparam int WIN = 200;
  logic mclk, rst, mode, sgn, pin_a, pin_b, valid, mact;
  logic [12:0] lines, fs, lv;
  logic [3:0] fshift;
  logic [31:0] cnt;
  logic [15:0] raw, filt, pct_o;
  int err_count, check_count, seed, exp_cnt, cyc, le, mag, rpm, pct, fsv, sh, acc, n, k;

  esm_speed_meas #(.INSTANCE(PULSE_DIR_INSTANCE), .SAMPLE_CYCLES(WIN)) uut (
    .mclk_i(mclk), .rst_i(rst), .pulse_input_terminal_i(pin_a), .direction_input_terminal_i(pin_b),
    .input_mode_i(mode), .sign_positive_i(sgn), .line_count_i(lines), .full_scale_speed_i(fs),
    .filter_shift_i(fshift), .enc_count_o(cnt), .raw_speed_rpm_o(raw), .filt_speed_rpm_o(filt),
    .speed_pct_o(pct_o), .speed_valid_o(valid), .mode_active_o(mact));
  esm_enc_model #(.HALF(10)) mdl (.mclk_i(mclk), .quad_i(mode), .a_o(pin_a), .b_o(pin_b));

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  // mirrors the window tick: zero at the first edge after release
  always @(posedge mclk) begin
    cyc <= rst ? 0 : cyc + 1;
  end

  function automatic int urand(input int m);
    urand = $unsigned($random(seed)) % m;
  endfunction
  task automatic end_sim;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk_cnt(input logic [31:0] got, input int exp);
    check_count++;
    if (got !== 32'(exp)) begin
      err_count++;
      $display("[FAIL] %0t count %0d exp %0d", $time, $signed(got), exp);
    end
  endtask
  task automatic chk_spd(input logic [15:0] got, input int exp);
    check_count++;
    if (got !== 16'(exp)) begin
      err_count++;
      $display("[FAIL] %0t speed %0d exp %0d", $time, $signed(got), exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t mode flag %b exp %b", $time, got, exp);
    end
  endtask
  task automatic set_cfg(input logic m, input logic s, input logic [12:0] l, input logic [12:0] f, input int t);
    @(posedge mclk);
    #1;
    mode = m;
    sgn = s;
    lines = l;
    fs = f;
    fshift = 4'(t);
    sh = t;
  endtask
  task automatic run(input int cnt_n, input logic fwd);
    repeat (cnt_n) begin
      mdl.step(fwd);
      exp_cnt += (fwd == sgn) ? 1 : -1;
    end
    repeat (5) @(negedge mclk);
    chk_cnt(cnt, exp_cnt);
  endtask
  task automatic wait_tick;
    do @(posedge mclk); while (cyc % WIN != 0);
  endtask
  task automatic wait_valid;
    int w;
    w = 0;
    @(negedge mclk);
    while (valid !== 1'b1 && w < 400) begin
      @(negedge mclk);
      w++;
    end
    if (w >= 400) begin
      err_count++;
      $display("[FAIL] %0t no speed result", $time);
    end
  endtask

  initial begin
    #2_000_000;
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim();
  end

  initial begin
    seed = 32'he7ae;
    {rst, mode, sgn, lines, fs, fshift} = {1'b1, 1'b0, 1'b1, 13'h000A, 13'h0000, 4'h0};
    sh = 0;
    exp_cnt = 0;
    repeat (5) @(posedge mclk);
    #1 rst = 1'b0;
    // every mode and polarity, moved both ways; quad runs whole lines so phase A ends low
    for (int i = 0; i < 4; i++) begin
      set_cfg(i[1], i[0], 13'(10 + urand(100)), 13'h1770, 0);
      repeat (4) @(negedge mclk);
      chk_flag(mact, mode);
      n = (1 + urand(8)) * (mode ? 4 : 1);
      k = (1 + urand(8)) * (mode ? 4 : 1);
      run(n, 1'b1);
      run(k, 1'b0);
    end
    // one burst inside a window, then an idle window; case 3 also exercises the filter
    for (int i = 0; i < 4; i++) begin
      lv = (i == 0) ? 13'h000A : (i == 2) ? 13'h1770 : (i == 3) ? 13'h0004 : 13'(10 + urand(4991));
      le = (lv < LINES_MIN) ? int'(LINES_MIN) : (lv > LINES_MAX) ? int'(LINES_MAX) : int'(lv);
      mag = (i[0] ? 16 : 8) * int'(RPM_RATE) / (i[0] ? 4 * le : le);
      // case 2 asks for a top speed at or beyond the limit, which must read as the limit
      fsv = (i == 3) ? 0 : (i == 0) ? mag : (i == 2) ? 6000 + urand(2192) : mag + urand(6001 - mag);
      rpm = (i == 1) ? -mag : mag;
      pct = (fsv == 0) ? 0 : mag * 1000 / ((fsv > int'(RPM_MAX)) ? int'(RPM_MAX) : fsv);
      pct = (i == 1) ? -pct : pct;
      set_cfg(i[0], i != 1, lv, 13'(fsv), (i == 3) ? 3 : 0);
      wait_tick();
      repeat (10) @(posedge mclk);
      run(i[0] ? 16 : 8, 1'b1);
      acc = (rpm * 4096) >>> sh;
      wait_valid();
      chk_spd(raw, rpm);
      chk_spd(filt, acc >>> 12);
      chk_spd(pct_o, pct);
      acc = acc + ((0 - acc) >>> sh);
      wait_valid();
      chk_spd(raw, 0);
      chk_spd(filt, acc >>> 12);
    end
    end_sim();
  end
endmodule // esm_speed_meas_test
`default_nettype wire
